/* logic/iap_flash_pkg.sv */
// Purpose: shared constants for the in-application flash erase/write controller
// Assumes: 250 MHz core clock, 8-bit register writes from the cpu
// Notes: register select codes are local to this block

package iap_flash_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int OP_TIME_US_X10 = 22;  // 2.2 ms, in tenths of a millisecond
    // divide first: the product of the tenths and the picoseconds would not fit in an int
    localparam int OP_CYCLES = OP_TIME_US_X10 * (100_000_000 / CLK_PERIOD_PS);
    localparam int UNLOCK_WINDOW_CYCLES = 256;
    localparam int OP_CNT_W = 20;
    localparam int UNLOCK_CNT_W = 16;

    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam int WORD_IDX_W = 5;
    localparam int PAGE_WORDS = 32;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int KEY_BYTES = 6;

    // ----------------------------------------
    // register select codes
    // ----------------------------------------
    localparam logic [3:0] SEL_CTRL0 = 4'h0;
    localparam logic [3:0] SEL_CTRL2 = 4'h1;
    localparam logic [3:0] SEL_ADDR_LO = 4'h2;
    localparam logic [3:0] SEL_ADDR_HI = 4'h3;
    localparam logic [3:0] SEL_DATA0_LO = 4'h4;
    localparam logic [3:0] SEL_DATA0_HI = 4'h5;
    localparam logic [3:0] SEL_KEY_LO1 = 4'h6;  // key bytes: lo1, lo2, lo3, hi1, hi2, hi3
    localparam logic [3:0] SEL_KEY_HI3 = 4'hB;

    // ----------------------------------------
    // control register 0 and 2 field positions
    // ----------------------------------------
    localparam int CTRL0_ENABLED_BIT = 7;
    localparam int CTRL0_MODE_HI = 6;
    localparam int CTRL0_MODE_LO = 4;
    localparam int CTRL0_TRIGGER_BIT = 3;
    localparam int CTRL0_WRITE_INIT_BIT = 2;
    localparam int CTRL2_CLEAR_BIT = 0;

    // ----------------------------------------
    // mode codes and key pattern
    // ----------------------------------------
    localparam logic [2:0] MODE_WRITE = 3'h0;
    localparam logic [2:0] MODE_PAGE_ERASE = 3'h1;
    localparam logic [2:0] MODE_UNLOCK = 3'h6;
    localparam logic [KEY_BYTES*BYTE_W-1:0] KEY_PATTERN = 48'h4009_04C3_0D00;  // lo1 in low byte
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_ERASE,
        OP_PROGRAM
    } op_state_t;

endpackage

/* logic/iap_flash_erase_write_ctrl.sv */
// Purpose: unlock sequence, page erase, page write buffer and write timing for the program flash
// Assumes: register writes arrive as one-cycle strobes on core_clk; flash array acts on start pulses
// Notes: erase and program run for a fixed cycle count and stall the cpu meanwhile

`timescale 1ns/1ps

module iap_flash_erase_write_ctrl #(
    parameter int ADDR_W = iap_flash_pkg::ADDR_W,
    parameter int OP_CYCLES = iap_flash_pkg::OP_CYCLES,
    parameter int UNLOCK_WINDOW_CYCLES = iap_flash_pkg::UNLOCK_WINDOW_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic [3:0] reg_sel,
    input wire logic [iap_flash_pkg::BYTE_W-1:0] reg_wdata,
    output logic [iap_flash_pkg::BYTE_W-1:0] flash_control_reg0,
    output logic buffer_clear_bit,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [iap_flash_pkg::BYTE_W-1:0] primary_data_low,
    output logic [iap_flash_pkg::BYTE_W-1:0] primary_data_high,
    output logic [ADDR_W-1:iap_flash_pkg::WORD_IDX_W] page_select,
    output logic [iap_flash_pkg::PAGE_WORDS-1:0][iap_flash_pkg::WORD_W-1:0] write_buf_words,
    output logic [iap_flash_pkg::PAGE_WORDS-1:0] write_buf_loaded,
    output logic flash_erase_start,
    output logic flash_prog_start,
    output logic cpu_stall
);
    import iap_flash_pkg::*;

    localparam logic [OP_CNT_W-1:0] OP_LAST = OP_CNT_W'(OP_CYCLES - 1);
    localparam logic [UNLOCK_CNT_W-1:0] UNLOCK_LAST = UNLOCK_CNT_W'(UNLOCK_WINDOW_CYCLES - 1);
    localparam logic [WORD_IDX_W-1:0] LAST_WORD = WORD_IDX_W'(PAGE_WORDS - 1);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic enabled;
        logic [2:0] mode;
        logic trigger;
        logic write_init;
        logic buf_clear;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data_lo;
        logic [BYTE_W-1:0] data_hi;
        logic [KEY_BYTES-1:0][BYTE_W-1:0] key;
        logic [KEY_BYTES-1:0] key_seen;
        logic [UNLOCK_CNT_W-1:0] unlock_cnt;
        logic [OP_CNT_W-1:0] op_cnt;
        op_state_t op;
        logic erase_pulse;
        logic prog_pulse;
        logic [PAGE_WORDS-1:0][WORD_W-1:0] buf_words;
        logic [PAGE_WORDS-1:0] buf_loaded;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;

    logic wr_ctrl0;
    logic wr_ctrl2;
    logic wr_hi;
    logic unlock_expire;
    logic op_done;
    logic key_ok;
    logic [3:0] key_off;

    // ----------------------------------------
    // decode of the register strobe
    // ----------------------------------------
    assign wr_ctrl0 = reg_wr && (reg_sel == SEL_CTRL0);
    assign wr_ctrl2 = reg_wr && (reg_sel == SEL_CTRL2);
    assign wr_hi = reg_wr && (reg_sel == SEL_DATA0_HI);
    assign key_off = reg_sel - SEL_KEY_LO1;
    assign unlock_expire = st.trigger && (st.unlock_cnt == UNLOCK_LAST);
    assign op_done = (st.op != OP_IDLE) && (st.op_cnt == OP_LAST);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.erase_pulse = 1'b0;
        next_st.prog_pulse = 1'b0;
        key_ok = 1'b0;

        // window timer runs only while triggered; expiry drops trigger and forgets keys
        if (st.trigger) begin
            next_st.unlock_cnt = st.unlock_cnt + UNLOCK_CNT_W'(1);
        end
        if (unlock_expire) begin
            next_st.trigger = 1'b0;
            next_st.key_seen = '0;
        end

        // software writes to control register 0
        if (wr_ctrl0) begin
            if (!reg_wdata[CTRL0_ENABLED_BIT]) begin
                next_st.enabled = 1'b0;
            end
            // writing one to the enable flag has no effect
            next_st.mode = reg_wdata[CTRL0_MODE_HI:CTRL0_MODE_LO];
            if (reg_wdata[CTRL0_TRIGGER_BIT] && reg_wdata[CTRL0_MODE_HI:CTRL0_MODE_LO] == MODE_UNLOCK) begin
                next_st.trigger = 1'b1;
                next_st.unlock_cnt = '0;
                next_st.key_seen = '0;
            end
            // initiate is only accepted once unlocked and in erase or write mode
            if (reg_wdata[CTRL0_WRITE_INIT_BIT] && st.enabled && st.op == OP_IDLE) begin
                if (reg_wdata[CTRL0_MODE_HI:CTRL0_MODE_LO] == MODE_PAGE_ERASE) begin
                    next_st.write_init = 1'b1;
                    next_st.op = OP_ERASE;
                    next_st.op_cnt = '0;
                    next_st.erase_pulse = 1'b1;
                end else if (reg_wdata[CTRL0_MODE_HI:CTRL0_MODE_LO] == MODE_WRITE) begin
                    next_st.write_init = 1'b1;
                    next_st.op = OP_PROGRAM;
                    next_st.op_cnt = '0;
                    next_st.prog_pulse = 1'b1;
                end
            end
        end

        // key bytes count only inside the window and in unlock mode
        if (reg_wr && reg_sel >= SEL_KEY_LO1 && reg_sel <= SEL_KEY_HI3) begin
            next_st.key[key_off[2:0]] = reg_wdata;
            if (st.trigger && !unlock_expire && st.mode == MODE_UNLOCK) begin
                next_st.key_seen[key_off[2:0]] = 1'b1;
            end
        end
        key_ok = (&next_st.key_seen) && (next_st.key == KEY_PATTERN);
        // hardware set beats a same-cycle software clear
        if (st.trigger && !unlock_expire && key_ok) begin
            next_st.enabled = 1'b1;
            next_st.key_seen = '0;
        end

        // address and primary data registers
        if (reg_wr && reg_sel == SEL_ADDR_LO) begin
            next_st.addr[BYTE_W-1:0] = reg_wdata;
        end
        if (reg_wr && reg_sel == SEL_ADDR_HI) begin
            next_st.addr[ADDR_W-1:BYTE_W] = reg_wdata[ADDR_W-BYTE_W-1:0];
        end
        if (reg_wr && reg_sel == SEL_DATA0_LO) begin
            next_st.data_lo = reg_wdata;
        end
        if (wr_hi) begin
            next_st.data_hi = reg_wdata;
            next_st.buf_words[st.addr[WORD_IDX_W-1:0]] = {reg_wdata, st.data_lo};
            next_st.buf_loaded[st.addr[WORD_IDX_W-1:0]] = 1'b1;
            // stop at the last word so a long burst cannot spill into the next page
            if (st.addr[WORD_IDX_W-1:0] != LAST_WORD) begin
                next_st.addr = st.addr + ADDR_W'(1);
            end
        end

        // buffer clear takes one cycle, then the bit drops
        if (st.buf_clear) begin
            next_st.buf_words = '0;
            next_st.buf_loaded = '0;
            next_st.buf_clear = 1'b0;
        end
        if (wr_ctrl2 && reg_wdata[CTRL2_CLEAR_BIT]) begin
            next_st.buf_clear = 1'b1;
        end

        // erase or program in flight
        case (st.op)
            OP_IDLE: begin
            end
            OP_ERASE, OP_PROGRAM: begin
                next_st.op_cnt = st.op_cnt + OP_CNT_W'(1);
                if (op_done) begin
                    next_st.op = OP_IDLE;
                    next_st.write_init = 1'b0;
                end
            end
            default: begin
                next_st.op = OP_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign flash_control_reg0 = {st.enabled, st.mode, st.trigger, st.write_init, 2'b00};
    assign buffer_clear_bit = st.buf_clear;
    assign flash_addr = st.addr;
    assign primary_data_low = st.data_lo;
    assign primary_data_high = st.data_hi;
    assign page_select = st.addr[ADDR_W-1:WORD_IDX_W];
    assign write_buf_words = st.buf_words;
    assign write_buf_loaded = st.buf_loaded;
    assign flash_erase_start = st.erase_pulse;
    assign flash_prog_start = st.prog_pulse;
    // cpu must not fetch while the array is busy
    assign cpu_stall = (st.op != OP_IDLE);

endmodule

/* tb/iap_flash_props.sv */
// Purpose: port-level checker for the flash erase/write controller
// Assumes: one clock domain, async active-high reset
// Notes: bound to every instance of the controller

`timescale 1ns/1ps

module iap_flash_props #(
    parameter int ADDR_W = 12,
    parameter int OP_CYCLES = 20,
    parameter int UNLOCK_WINDOW_CYCLES = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic [3:0] reg_sel,
    input wire logic [iap_flash_pkg::BYTE_W-1:0] reg_wdata,
    input wire logic [iap_flash_pkg::BYTE_W-1:0] flash_control_reg0,
    input wire logic buffer_clear_bit,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [ADDR_W-1:iap_flash_pkg::WORD_IDX_W] page_select,
    input wire logic [iap_flash_pkg::PAGE_WORDS-1:0] write_buf_loaded,
    input wire logic flash_erase_start,
    input wire logic flash_prog_start,
    input wire logic cpu_stall
);
    import iap_flash_pkg::*;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    logic wr_c;
    logic [7:0] c0;
    logic [OP_CNT_W-1:0] init_run;
    // taken writes only; a frozen clock enable drops the strobe
    assign wr_c = clk_en && reg_wr;
    assign c0 = flash_control_reg0;
    // cycles the initiate bit has stood; a counter keeps the full op length out of a delay
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            init_run <= '0;
        end else if (clk_en) begin
            init_run <= c0[2] ? init_run + OP_CNT_W'(1) : '0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    hw_set_only_a: assert property ($rose(c0[7]) |-> $past(wr_c && reg_sel == SEL_KEY_HI3))
        else $error("enable flag rose without final key write");
    init_gate_a: assert property ($rose(c0[2]) |-> $past(c0[7]))
        else $error("operation started while locked");
    stall_follow_a: assert property (cpu_stall == c0[2])
        else $error("stall differs from initiate bit");
    init_len_a: assert property ($fell(c0[2]) |-> init_run == OP_CNT_W'(OP_CYCLES))
        else $error("initiate bit length wrong");
    init_max_a: assert property (c0[2] |-> init_run < OP_CNT_W'(OP_CYCLES))
        else $error("initiate bit stood too long");
    start_kind_a: assert property ($rose(c0[2]) |-> flash_erase_start == (c0[6:4] == MODE_PAGE_ERASE)
        && flash_prog_start == (c0[6:4] == MODE_WRITE) ##1 !flash_erase_start && !flash_prog_start)
        else $error("start pulse wrong");
    win_expire_a: assert property ($rose(c0[3]) |-> ##(UNLOCK_WINDOW_CYCLES-1) c0[3] ##1 !c0[3])
        else $error("unlock window length wrong");
    clear_done_a: assert property ($rose(buffer_clear_bit) |=> !buffer_clear_bit && write_buf_loaded == '0)
        else $error("buffer clear did not finish");
    addr_step_a: assert property (wr_c && reg_sel == SEL_DATA0_HI |=> write_buf_loaded[$past(flash_addr[4:0])]
        && flash_addr == ((&$past(flash_addr[4:0])) ? $past(flash_addr) : $past(flash_addr) + 1'b1))
        else $error("buffer address step wrong");
    sw_clear_a: assert property (wr_c && reg_sel == SEL_CTRL0 && !reg_wdata[7] |=> !c0[7])
        else $error("software clear of enable flag ignored");
    page_map_a: assert property (page_select == flash_addr[ADDR_W-1:5])
        else $error("page select differs from address");
endmodule

bind iap_flash_erase_write_ctrl iap_flash_props #(.ADDR_W(ADDR_W), .OP_CYCLES(OP_CYCLES),
    .UNLOCK_WINDOW_CYCLES(UNLOCK_WINDOW_CYCLES)) props_inst (.core_clk, .rst, .clk_en, .reg_wr, .reg_sel,
    .reg_wdata, .flash_control_reg0, .buffer_clear_bit, .flash_addr, .page_select, .write_buf_loaded,
    .flash_erase_start, .flash_prog_start, .cpu_stall);

/* tb/testbench.sv */
// Purpose: self-checking bench for the flash erase/write controller
// Assumes: short op and window counts for simulation
// Notes: random words come from an lfsr seeded with 77

`timescale 1ns/1ps

module testbench;
    import iap_flash_pkg::*;
    // ----------------------------------------
    // signals and helpers
    // ----------------------------------------
    localparam int OPC = 20;
    localparam int WIN = 16;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic reg_wr = 1'b0;
    logic [3:0] reg_sel = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] fc0;
    logic [11:0] addr;
    logic [11:5] psel;
    logic [PAGE_WORDS-1:0][WORD_W-1:0] words;
    logic [PAGE_WORDS-1:0][WORD_W-1:0] exp_words = '0;
    logic [PAGE_WORDS-1:0] loaded;
    logic clr, erase_go, prog_go, stall;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [6:0] pg;
    logic [4:0] idx;
    logic [15:0] lfsr = 16'h004D;
    int mismatches = 0;
    int compares = 0;
    iap_flash_erase_write_ctrl #(.OP_CYCLES(OPC), .UNLOCK_WINDOW_CYCLES(WIN)) iap_flash_erase_write_ctrl_inst (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .flash_control_reg0(fc0), .buffer_clear_bit(clr), .flash_addr(addr),
        .primary_data_low(dlo), .primary_data_high(dhi), .page_select(psel), .write_buf_words(words),
        .write_buf_loaded(loaded), .flash_erase_start(erase_go), .flash_prog_start(prog_go), .cpu_stall(stall));
    always #2 core_clk = ~core_clk;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // buffer index saturates so overflow words land on the last slot
    function automatic logic [4:0] next_idx(input logic [4:0] i);
        return (i == 5'h1F) ? i : i + 5'h01;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one write strobe, taken only while clk_en is high; returns just after the edge so new values are settled
    task automatic wr(input logic [3:0] sel, input logic [7:0] data);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_sel <= sel;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic unlock(input logic [47:0] key);
        wr(SEL_CTRL0, 8'h68);
        for (int i = 0; i < 6; i++) begin
            wr(4'(SEL_KEY_LO1 + i), key[8*i +: 8]);
        end
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #(4 * 5000);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check("ctrl0 reset", {fc0, addr}, 20'h0_0000);
        wr(SEL_CTRL0, 8'h80);
        check("sw set flag", fc0[7], 1'b0);
        wr(SEL_CTRL0, 8'h78);
        check("trigger bad mode", fc0[3], 1'b0);
        wr(SEL_CTRL0, 8'h14);
        check("init while locked", fc0[2], 1'b0);
        unlock(48'h4009_04C3_0D01);
        check("bad key", fc0[7], 1'b0);
        step(WIN);
        check("bad key expired", fc0[3], 1'b0);
        unlock(48'h4009_04C3_0D00);
        check("good key", fc0[7:3], 5'b1_1101);
        step(WIN);
        check("good key expired", fc0[3], 1'b0);
        $display("test unlock done");
        pg = lfsr[6:0];
        wr(SEL_ADDR_LO, {pg[2:0], 5'h00});
        wr(SEL_ADDR_HI, {4'h0, pg[6:3]});
        check("page select", psel, pg);
        // the page is erased before any word of it is programmed
        wr(SEL_CTRL0, 8'h94);
        check("erase start", {erase_go, prog_go, stall}, 3'b101);
        step(OPC);
        // initiate low is what the caller waits for before its blank check
        check("erase done", {fc0[7], fc0[2], stall}, 3'b100);
        $display("test erase done");
        wr(SEL_CTRL0, 8'h80);
        idx = 5'h00;
        // exactly one page; the last word shows the address holding at the page end
        for (int i = 0; i < PAGE_WORDS; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(SEL_DATA0_LO, lfsr[7:0]);
            wr(SEL_DATA0_HI, lfsr[15:8]);
            exp_words[idx] = lfsr;
            check("data regs", {dhi, dlo}, lfsr);
            check("addr step", addr, {pg, next_idx(idx)});
            idx = next_idx(idx);
        end
        check("loaded", loaded, 32'hFFFF_FFFF);
        for (int i = 0; i < PAGE_WORDS; i++) begin
            check("buffer word", words[i], exp_words[i]);
        end
        wr(SEL_CTRL0, 8'h84);
        check("program start", {erase_go, prog_go, stall}, 3'b011);
        step(OPC);
        check("program done", fc0[2], 1'b0);
        $display("test program done");
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(SEL_CTRL2, 8'h01);
        check("frozen clear", clr, 1'b0);
        @(posedge core_clk);
        clk_en <= 1'b1;
        wr(SEL_CTRL2, 8'h01);
        check("clear busy", clr, 1'b1);
        step(1);
        check("clear done", clr, 1'b0);
        check("clear empty", loaded, 32'h0000_0000);
        wr(SEL_CTRL0, 8'h00);
        check("sw clear flag", fc0[7], 1'b0);
        wr(SEL_CTRL0, 8'h94);
        check("init after clear", fc0[2], 1'b0);
        $display("test clear done");
        summarize();
    end
endmodule
